// ---- common/pie_pkg.sv ----
// Purpose: constants for the single-octet element codec
// Assumes: octets are carried bit 1 in the lsb position
// Notes: identifier patterns for all element kinds, parameter codes for line and state only
`default_nettype none
package pie_pkg;
	// single-octet identifiers
	localparam logic [7:0] PIE_PULSE_NOTE = 8'hc0;
	localparam logic [3:0] PIE_HI_LINE = 4'h8;
	localparam logic [3:0] PIE_HI_STATE = 4'h9;
	localparam logic [3:0] PIE_HI_AUTO = 4'ha;
	localparam logic [3:0] PIE_HI_RESP = 4'hb;
	// line information codes
	localparam logic [3:0] PIE_LINE_MAX = 4'h4;
	// state field codes
	localparam logic [3:0] PIE_STATE_MAX = 4'h7;
	localparam logic [3:0] PIE_STATE_NA = 4'hf;
	// variable-length identifiers and length limits
	localparam int PIE_NVAR = 14;
	localparam logic [7:0] PIE_VAR_ID [PIE_NVAR] = '{8'h00, 8'h01, 8'h02,
		8'h03, 8'h04, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h22, 8'h23,
		8'h24, 8'h24};
	localparam logic [3:0] PIE_VAR_MIN [PIE_NVAR] = '{4'h3, 4'h3, 4'h3,
		4'h3, 4'h3, 4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h3, 4'h3};
	localparam logic [3:0] PIE_VAR_MAX [PIE_NVAR] = '{4'h3, 4'h3, 4'h5,
		4'h3, 4'h3, 4'h4, 4'h6, 4'h3, 4'h5, 4'h8, 4'h7, 4'h5, 4'hf, 4'hf};
	// element kinds, also the bit index in the seen mask
	typedef enum logic [2:0] {
		PIE_K_NOTE = 3'd0,
		PIE_K_LINE = 3'd1,
		PIE_K_STATE = 3'd2,
		PIE_K_AUTO = 3'd3,
		PIE_K_RESP = 3'd4,
		PIE_K_VAR = 3'd5,
		PIE_K_RSVD = 3'd6
	} pie_kind_t;
	// serialiser width
	localparam int PIE_OCTET_BITS = 8;
endpackage
`default_nettype wire

// ---- common/pie_stream_if.sv ----
// Purpose: valid/ready octet stream between codec modules
// Assumes: one clock, transfer when valid and ready are both high
// Notes: last marks the final octet of a message
`default_nettype none
interface pie_stream_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	logic last;
	modport src (output valid, output data, output last, input ready);
	modport snk (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// ---- src/pie_buf2.sv ----
// Purpose: two-entry skid buffer for the octet stream
// Assumes: synchronous active-high reset
// Notes: full throughput; ready upstream is registered-free but honest
`default_nettype none
module pie_buf2 (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// streams
	pie_stream_if.snk up,
	pie_stream_if.src dn
);
	import pie_pkg::*;
	logic [8:0] mem [2];
	logic rd_ptr;
	logic wr_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign up.ready = (count != 2'd2);
	assign dn.valid = (count != 2'd0);
	assign {dn.last, dn.data} = mem[rd_ptr];
	assign push = up.valid && up.ready;
	assign pop = dn.valid && dn.ready;

	// storage, written only on a push
	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem[wr_ptr] <= {up.last, up.data};
		end
	end

	// pointers and occupancy
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (push) wr_ptr <= ~wr_ptr;
			if (pop) rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	// occupancy can never pass the two entries that exist
	property p_no_over;
		@(posedge mclk_i) disable iff (srst_i)
		count <= 2'd2;
	endproperty
	a_no_over: assert property (p_no_over)
		else $error("buffer count overflow");
endmodule
`default_nettype wire

// ---- src/pie_ser.sv ----
// Purpose: octet to bit serialiser, bit 1 first
// Assumes: drains the buffered stream one octet per nine clocks
// Notes: stalls the buffer while a shift is in progress
`default_nettype none
module pie_ser (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// octet input
	pie_stream_if.snk in,
	// serial output
	output logic ser_bit_o,
	output logic ser_valid_o,
	output logic ser_last_o
);
	import pie_pkg::*;
	logic [7:0] shreg;
	logic [2:0] cnt;
	logic busy;
	logic last_oct;

	assign in.ready = !busy;

	// shift out lsb first, octet order preserved by the stream
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			shreg <= 8'h00;
			cnt <= 3'd0;
			busy <= 1'b0;
			last_oct <= 1'b0;
		end else if (!busy && in.valid) begin
			shreg <= in.data;
			last_oct <= in.last;
			cnt <= 3'd0;
			busy <= 1'b1;
		end else if (busy) begin
			shreg <= {1'b0, shreg[7:1]};
			cnt <= cnt + 3'd1;
			if (cnt == 3'(PIE_OCTET_BITS - 1)) busy <= 1'b0;
		end
	end

	// registered data outputs
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			ser_bit_o <= 1'b0;
			ser_valid_o <= 1'b0;
			ser_last_o <= 1'b0;
		end else begin
			ser_bit_o <= shreg[0];
			ser_valid_o <= busy;
			ser_last_o <= busy && last_oct
				&& (cnt == 3'(PIE_OCTET_BITS - 1));
		end
	end

	property p_ser_len;
		@(posedge mclk_i) disable iff (srst_i)
		(!busy && in.valid) |=> busy [*8] ##1 !busy;
	endproperty
	a_ser_len: assert property (p_ser_len)
		else $error("octet did not take eight bit times");
endmodule
`default_nettype wire

// ---- src/pie_codec.sv ----
// Purpose: single-octet element builder and element classifier
// Assumes: device sits on the access network side of the link
// Notes: variable-length bodies are skipped by their length octet, or end early at the last octet of a message
`default_nettype none
module pie_codec (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// inbound octets from exchange side
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_last_i,
	output logic rx_ready_o,
	// inbound decode results
	output logic [2:0] rx_kind_o,
	output logic [3:0] rx_content_o,
	output logic rx_elem_o,
	output logic seq_start_o,
	output logic [3:0] seq_type_o,
	output logic err_rsvd_id_o,
	output logic err_rsvd_code_o,
	output logic err_dir_o,
	output logic err_repeat_o,
	output logic err_len_o,
	// notification request from pulse/digit decoding
	input wire logic note_req_i,
	input wire logic pulse_done_i,
	// outbound element requests
	input wire logic line_req_i,
	input wire logic [3:0] line_code_i,
	input wire logic path_up_i,
	input wire logic state_req_i,
	input wire logic [3:0] fsm_state_i,
	input wire logic resp_req_i,
	input wire logic [3:0] resp_type_i,
	output logic tx_busy_o,
	output logic tx_drop_o,
	// serial output toward exchange side
	output logic ser_bit_o,
	output logic ser_valid_o,
	output logic ser_last_o
);
	import pie_pkg::*;

	pie_stream_if tx_s ();
	pie_stream_if ser_s ();

	typedef enum logic [1:0] {
		PIE_ST_ID = 2'b00,
		PIE_ST_LEN = 2'b01,
		PIE_ST_BODY = 2'b11
	} pie_rx_st_t;

	pie_rx_st_t rx_st;
	logic [3:0] body_left;
	logic [3:0] var_min;
	logic [3:0] var_max;
	logic var_hit;
	logic [7:0] seen;
	logic [2:0] kind;
	logic rx_take;
	logic note_armed;
	logic note_pend;
	logic [7:0] tx_oct;
	logic tx_pend;
	logic [2:0] tx_sel;
	logic [7:0] next_tx_oct;
	logic [3:0] var_min_q;
	logic [3:0] var_max_q;

	// inbound octets are always accepted
	assign rx_ready_o = 1'b1;
	assign rx_take = rx_valid_i;

	// variable-length identifier table lookup
	always_comb begin
		var_hit = 1'b0;
		var_min = 4'h0;
		var_max = 4'h0;
		for (int i = 0; i < PIE_NVAR; i++) begin
			if (rx_data_i == PIE_VAR_ID[i] && !var_hit) begin
				var_hit = 1'b1;
				var_min = PIE_VAR_MIN[i];
				var_max = PIE_VAR_MAX[i];
			end
		end
	end

	// identifier classification; no shift codes exist in one codeset
	always_comb begin
		kind = PIE_K_RSVD;
		if (rx_data_i[7]) begin
			if (rx_data_i == PIE_PULSE_NOTE) kind = PIE_K_NOTE;
			else if (rx_data_i[7:4] == PIE_HI_LINE) kind = PIE_K_LINE;
			else if (rx_data_i[7:4] == PIE_HI_STATE) kind = PIE_K_STATE;
			else if (rx_data_i[7:4] == PIE_HI_AUTO) kind = PIE_K_AUTO;
			else if (rx_data_i[7:4] == PIE_HI_RESP) kind = PIE_K_RESP;
		end else if (!rx_data_i[6] && var_hit) begin
			kind = PIE_K_VAR;
		end
	end

	// receive walker: id, length, body skip
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rx_st <= PIE_ST_ID;
			body_left <= 4'h0;
		end else if (rx_take) begin
			unique case (rx_st)
				PIE_ST_ID: begin
					if (kind == PIE_K_VAR && !rx_last_i) rx_st <= PIE_ST_LEN;
				end
				PIE_ST_LEN: begin
					body_left <= rx_data_i[3:0];
					rx_st <= (rx_data_i == 8'h00 || rx_last_i) ?
						PIE_ST_ID : PIE_ST_BODY;
				end
				PIE_ST_BODY: begin
					body_left <= body_left - 4'h1;
					if (body_left == 4'h1 || rx_last_i) rx_st <= PIE_ST_ID;
				end
				default: rx_st <= PIE_ST_ID;
			endcase
		end
	end

	// length check against the identifier's permitted total
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			var_min_q <= 4'h0;
			var_max_q <= 4'h0;
			err_len_o <= 1'b0;
		end else begin
			err_len_o <= 1'b0;
			if (rx_take && rx_st == PIE_ST_ID && kind == PIE_K_VAR) begin
				var_min_q <= var_min;
				var_max_q <= var_max;
			end
			if (rx_take && rx_st == PIE_ST_LEN) begin
				// total length is content plus two header octets
				err_len_o <= (rx_data_i > 8'(var_max_q - 4'h2)) ||
					(rx_data_i < 8'(var_min_q - 4'h2));
			end
		end
	end

	// per-element decode and error flags, one-cycle pulses
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rx_kind_o <= PIE_K_RSVD;
			rx_content_o <= 4'h0;
			rx_elem_o <= 1'b0;
			seq_start_o <= 1'b0;
			seq_type_o <= 4'h0;
			err_rsvd_id_o <= 1'b0;
			err_rsvd_code_o <= 1'b0;
			err_dir_o <= 1'b0;
			err_repeat_o <= 1'b0;
		end else begin
			rx_elem_o <= 1'b0;
			seq_start_o <= 1'b0;
			err_rsvd_id_o <= 1'b0;
			err_rsvd_code_o <= 1'b0;
			err_dir_o <= 1'b0;
			err_repeat_o <= 1'b0;
			if (rx_take && rx_st == PIE_ST_ID) begin
				rx_elem_o <= 1'b1;
				rx_kind_o <= kind;
				rx_content_o <= rx_data_i[3:0];
				err_rsvd_id_o <= (kind == PIE_K_RSVD);
				// outbound-only kinds arriving inbound
				err_dir_o <= (kind == PIE_K_NOTE || kind == PIE_K_LINE ||
					kind == PIE_K_STATE || kind == PIE_K_RESP);
				err_rsvd_code_o <= (kind == PIE_K_LINE &&
					rx_data_i[3:0] > PIE_LINE_MAX);
				err_repeat_o <= (kind != PIE_K_RSVD && kind != PIE_K_VAR &&
					seen[kind]);
				if (kind == PIE_K_AUTO) begin
					seq_start_o <= 1'b1;
					seq_type_o <= rx_data_i[3:0];
				end
			end
		end
	end

	// single-octet elements seen in the current message
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			seen <= 8'h00;
		end else if (rx_take && rx_last_i) begin
			seen <= 8'h00;
		end else if (rx_take && rx_st == PIE_ST_ID && kind < PIE_K_VAR) begin
			seen[kind] <= 1'b1;
		end
	end

	// notification armed by the latest request only
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			note_armed <= 1'b0;
			note_pend <= 1'b0;
		end else begin
			if (note_req_i) note_armed <= 1'b1;
			else if (pulse_done_i && note_armed) note_armed <= 1'b0;
			// set wins over the clear by the send
			if (pulse_done_i && note_armed) note_pend <= 1'b1;
			else if (tx_sel == PIE_K_NOTE && !tx_pend) note_pend <= 1'b0;
		end
	end

	// outbound selection: one element at a time, fixed priority
	always_comb begin
		tx_sel = PIE_K_RSVD;
		next_tx_oct = 8'h00;
		if (note_pend) begin
			tx_sel = PIE_K_NOTE;
			next_tx_oct = PIE_PULSE_NOTE;
		end else if (state_req_i) begin
			tx_sel = PIE_K_STATE;
			next_tx_oct = {PIE_HI_STATE, (fsm_state_i > PIE_STATE_MAX) ?
				PIE_STATE_NA : fsm_state_i};
		end else if (resp_req_i) begin
			tx_sel = PIE_K_RESP;
			next_tx_oct = {PIE_HI_RESP, resp_type_i};
		end else if (line_req_i && !path_up_i &&
			line_code_i <= PIE_LINE_MAX) begin
			tx_sel = PIE_K_LINE;
			next_tx_oct = {PIE_HI_LINE, line_code_i};
		end
	end

	// single-octet holding register feeding the buffer
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tx_oct <= 8'h00;
			tx_pend <= 1'b0;
			tx_drop_o <= 1'b0;
		end else begin
			tx_drop_o <= line_req_i && !tx_pend && !note_pend &&
				!state_req_i && !resp_req_i &&
				(path_up_i || line_code_i > PIE_LINE_MAX);
			if (tx_pend && tx_s.ready) begin
				tx_pend <= 1'b0;
			end else if (!tx_pend && tx_sel != PIE_K_RSVD) begin
				tx_oct <= next_tx_oct;
				tx_pend <= 1'b1;
			end
		end
	end

	assign tx_s.valid = tx_pend;
	assign tx_s.data = tx_oct;
	assign tx_s.last = 1'b1;
	assign tx_busy_o = tx_pend;

	pie_buf2 u_buf (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.up(tx_s),
		.dn(ser_s)
	);

	pie_ser u_ser (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.in(ser_s),
		.ser_bit_o(ser_bit_o),
		.ser_valid_o(ser_valid_o),
		.ser_last_o(ser_last_o)
	);

	// inbound autonomous sequence yields start pulse next cycle
	property p_auto_start;
		@(posedge mclk_i) disable iff (srst_i)
		(rx_take && rx_st == PIE_ST_ID && rx_data_i[7:4] == PIE_HI_AUTO)
		|=> seq_start_o && seq_type_o == $past(rx_data_i[3:0]);
	endproperty
	a_auto_start: assert property (p_auto_start)
		else $error("autonomous sequence not started");

	property p_line_rsvd;
		@(posedge mclk_i) disable iff (srst_i)
		(rx_take && rx_st == PIE_ST_ID && rx_data_i[7:4] == PIE_HI_LINE &&
		rx_data_i[3:0] > PIE_LINE_MAX) |=> err_rsvd_code_o;
	endproperty
	a_line_rsvd: assert property (p_line_rsvd)
		else $error("reserved line code not flagged");

	property p_rsvd_id;
		@(posedge mclk_i) disable iff (srst_i)
		(rx_take && rx_st == PIE_ST_ID && rx_data_i[7:6] == 2'b01)
		|=> err_rsvd_id_o;
	endproperty
	a_rsvd_id: assert property (p_rsvd_id)
		else $error("reserved identifier not flagged");

	property p_dir;
		@(posedge mclk_i) disable iff (srst_i)
		(rx_take && rx_st == PIE_ST_ID && rx_data_i[7:4] == PIE_HI_RESP)
		|=> err_dir_o && !seq_start_o;
	endproperty
	a_dir: assert property (p_dir)
		else $error("inbound response not flagged");

	sequence s_note_done;
		note_armed && pulse_done_i && !note_req_i;
	endsequence
	property p_note;
		@(posedge mclk_i) disable iff (srst_i)
		s_note_done |=> note_pend
			##[0:20] (tx_pend && tx_oct == PIE_PULSE_NOTE);
	endproperty
	a_note: assert property (p_note)
		else $error("pulse notification not emitted");

	property p_note_unarmed;
		@(posedge mclk_i) disable iff (srst_i)
		(!note_armed && !note_pend) |=> !note_pend;
	endproperty
	a_note_unarmed: assert property (p_note_unarmed)
		else $error("notification without request");

	property p_line_path;
		@(posedge mclk_i) disable iff (srst_i)
		(tx_s.valid && tx_s.data[7:4] == PIE_HI_LINE) |->
		tx_s.data[3:0] <= PIE_LINE_MAX;
	endproperty
	a_line_path: assert property (p_line_path)
		else $error("bad line information sent");

	// a line element may only be loaded while no path exists
	property p_line_nopath;
		@(posedge mclk_i) disable iff (srst_i)
		($rose(tx_pend) && tx_oct[7:4] == PIE_HI_LINE) |-> !$past(path_up_i);
	endproperty
	a_line_nopath: assert property (p_line_nopath)
		else $error("line information sent while path present");

	property p_state;
		@(posedge mclk_i) disable iff (srst_i)
		(!tx_pend && tx_sel == PIE_K_STATE) |=>
		tx_pend && tx_oct[7:4] == PIE_HI_STATE &&
		(tx_oct[3:0] <= PIE_STATE_MAX || tx_oct[3:0] == PIE_STATE_NA);
	endproperty
	a_state: assert property (p_state)
		else $error("state element misencoded");

	property p_repeat;
		@(posedge mclk_i) disable iff (srst_i)
		(rx_take && rx_st == PIE_ST_ID && kind == PIE_K_AUTO && seen[3])
		|=> err_repeat_o;
	endproperty
	a_repeat: assert property (p_repeat)
		else $error("repeated element not flagged");
endmodule
`default_nettype wire

// ---- bench/pie_xchg_model.sv ----
// Purpose: exchange side receiver model for the serial element stream
// Assumes: bits arrive least significant first while ser_valid is high
// Notes: flags a frame error when the last marker is misplaced
`default_nettype none
module pie_xchg_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// serial input from the codec
	input wire logic ser_bit_i,
	input wire logic ser_valid_i,
	input wire logic ser_last_i,
	// rebuilt octets
	output logic [7:0] oct_o,
	output logic oct_stb_o,
	output logic frame_err_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] idx;
	logic [7:0] sh;
	// reassemble octets, bit 1 lands in the lsb
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			idx <= 3'h0;
			sh <= 8'h00;
			oct_o <= 8'h00;
			oct_stb_o <= 1'b0;
			frame_err_o <= 1'b0;
		end else begin
			oct_stb_o <= 1'b0;
			if (ser_valid_i) begin
				sh[idx] <= ser_bit_i;
				idx <= idx + 3'h1;
				// last must mark bit 8 exactly, one octet per element
				if ((idx == 3'h7) != ser_last_i) begin
					frame_err_o <= 1'b1;
				end
				if (idx == 3'h7) begin
					oct_o <= {ser_bit_i, sh[6:0]};
					oct_stb_o <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the element codec
// Assumes: inputs change 1 ns after the rising edge
// Notes: outbound octets are judged by the exchange side model
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pie_pkg::*;
	logic mclk_i, srst_i, rx_valid_i, rx_last_i, rx_ready_o, rx_elem_o;
	logic [7:0] rx_data_i, oct;
	logic [2:0] rx_kind_o;
	logic [3:0] rx_content_o, seq_type_o, line_code_i, fsm_state_i;
	logic [3:0] resp_type_i;
	logic seq_start_o, err_rsvd_id_o, err_rsvd_code_o, err_dir_o;
	logic err_repeat_o, err_len_o, note_req_i, pulse_done_i, line_req_i;
	logic path_up_i, state_req_i, resp_req_i, tx_busy_o, tx_drop_o;
	logic ser_bit_o, ser_valid_o, ser_last_o, oct_stb, frame_err;
	logic len_seen, drop_seen, busy_seen;
	int fails, comparisons;
	pie_codec dut (.mclk_i(mclk_i), .srst_i(srst_i), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
		.rx_kind_o(rx_kind_o), .rx_content_o(rx_content_o),
		.rx_elem_o(rx_elem_o), .seq_start_o(seq_start_o),
		.seq_type_o(seq_type_o), .err_rsvd_id_o(err_rsvd_id_o),
		.err_rsvd_code_o(err_rsvd_code_o), .err_dir_o(err_dir_o),
		.err_repeat_o(err_repeat_o), .err_len_o(err_len_o),
		.note_req_i(note_req_i), .pulse_done_i(pulse_done_i),
		.line_req_i(line_req_i), .line_code_i(line_code_i),
		.path_up_i(path_up_i), .state_req_i(state_req_i),
		.fsm_state_i(fsm_state_i), .resp_req_i(resp_req_i),
		.resp_type_i(resp_type_i), .tx_busy_o(tx_busy_o),
		.tx_drop_o(tx_drop_o), .ser_bit_o(ser_bit_o),
		.ser_valid_o(ser_valid_o), .ser_last_o(ser_last_o));
	pie_xchg_model far (.mclk_i(mclk_i), .srst_i(srst_i),
		.ser_bit_i(ser_bit_o), .ser_valid_i(ser_valid_o),
		.ser_last_i(ser_last_o), .oct_o(oct), .oct_stb_o(oct_stb),
		.frame_err_o(frame_err));
	// 25 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	// sticky catch of one-cycle pulses, off the launching edge
	always @(negedge mclk_i) begin
		if (err_len_o === 1'b1) len_seen = 1'b1;
		if (tx_drop_o === 1'b1) drop_seen = 1'b1;
		if (tx_busy_o === 1'b1) busy_seen = 1'b1;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// one inbound octet; decode outputs are settled on return
	task automatic rx(input logic [7:0] d, input logic l);
		@(posedge mclk_i);
		#1;
		rx_valid_i = 1'b1;
		rx_data_i = d;
		rx_last_i = l;
		@(posedge mclk_i);
		#1;
		rx_valid_i = 1'b0;
		rx_last_i = 1'b0;
	endtask
	// k: 0 notification, 1 line, 2 state, 3 response
	task automatic tx(input int k, input logic [3:0] v, input logic [7:0] exp);
		int n;
		logic got;
		got = 1'b0;
		@(posedge mclk_i);
		#1;
		note_req_i = (k == 0);
		line_req_i = (k == 1);
		state_req_i = (k == 2);
		resp_req_i = (k == 3);
		line_code_i = v;
		fsm_state_i = v;
		resp_type_i = v;
		if (k == 0) begin
			@(posedge mclk_i);
			#1;
			note_req_i = 1'b0;
			pulse_done_i = 1'b1;
			@(posedge mclk_i);
			#1;
			pulse_done_i = 1'b0;
		end
		for (n = 0; n < 20 && tx_busy_o !== 1'b1; n++) begin
			@(posedge mclk_i);
			#1;
		end
		line_req_i = 1'b0;
		state_req_i = 1'b0;
		resp_req_i = 1'b0;
		for (n = 0; n < 100 && got !== 1'b1; n++) begin
			@(posedge mclk_i);
			#1;
			got = oct_stb;
		end
		check({7'h0, got}, 8'h01);
		check(oct, exp);
	endtask
	// watchdog at 20000 cycles, far beyond the several hundred cycles the tests need
	initial begin
		#800000;
		fails++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] ids [4];
		logic [2:0] kinds [4];
		ids = '{8'hc0, 8'h83, 8'h95, 8'hb2};
		kinds = '{PIE_K_NOTE, PIE_K_LINE, PIE_K_STATE, PIE_K_RESP};
		{rx_valid_i, rx_last_i, note_req_i, pulse_done_i} = 4'h0;
		{line_req_i, path_up_i, state_req_i, resp_req_i} = 4'h0;
		{rx_data_i, line_code_i, fsm_state_i, resp_type_i} = 20'h0;
		{len_seen, drop_seen, busy_seen} = 3'h0;
		fails = 0;
		comparisons = 0;
		srst_i = 1'b1;
		repeat (16) @(posedge mclk_i);
		#1;
		srst_i = 1'b0;
		check({5'h0, rx_kind_o}, {5'h0, PIE_K_RSVD});
		// every autonomous sequence type starts its sequence
		for (int t = 0; t < 16; t++) begin
			rx({4'ha, t[3:0]}, 1'b1);
			check({7'h0, seq_start_o}, 8'h01);
			check({4'h0, seq_type_o}, {4'h0, t[3:0]});
			check({5'h0, rx_kind_o}, {5'h0, PIE_K_AUTO});
			check({7'h0, err_dir_o}, 8'h00);
			check({7'h0, rx_ready_o}, 8'h01);
		end
		$display("test autonomous sequence done");
		// outbound-only elements arriving inbound
		for (int i = 0; i < 4; i++) begin
			rx(ids[i], 1'b1);
			check({7'h0, err_dir_o}, 8'h01);
			check({5'h0, rx_kind_o}, {5'h0, kinds[i]});
			check({4'h0, rx_content_o}, {4'h0, ids[i][3:0]});
			check({7'h0, err_rsvd_code_o}, 8'h00);
			check({7'h0, err_rsvd_id_o}, 8'h00);
			check({7'h0, seq_start_o}, 8'h00);
		end
		rx(8'h85, 1'b1);
		check({7'h0, err_rsvd_code_o}, 8'h01);
		rx(8'h40, 1'b1);
		check({7'h0, err_rsvd_id_o}, 8'h01);
		rx(8'h21, 1'b1);
		check({5'h0, rx_kind_o}, {5'h0, PIE_K_RSVD});
		check({7'h0, err_rsvd_id_o}, 8'h01);
		// pulse notification pattern with content bits is not an element
		rx(8'hc5, 1'b1);
		check({5'h0, rx_kind_o}, {5'h0, PIE_K_RSVD});
		check({7'h0, err_rsvd_id_o}, 8'h01);
		$display("test direction and reserved done");
		// repeat within a message, then a fresh message
		rx(8'ha1, 1'b0);
		check({7'h0, err_repeat_o}, 8'h00);
		rx(8'ha2, 1'b1);
		check({7'h0, err_repeat_o}, 8'h01);
		rx(8'ha2, 1'b1);
		check({7'h0, err_repeat_o}, 8'h00);
		// variable element body must not decode as an identifier
		len_seen = 1'b0;
		rx(8'h02, 1'b0);
		check({5'h0, rx_kind_o}, {5'h0, PIE_K_VAR});
		rx(8'h03, 1'b0);
		rx(8'ha5, 1'b0);
		rx(8'h85, 1'b0);
		rx(8'hc0, 1'b1);
		check({6'h0, rx_elem_o, seq_start_o}, 8'h00);
		check({7'h0, len_seen}, 8'h00);
		rx(8'h00, 1'b0);
		rx(8'h02, 1'b0);
		rx(8'h11, 1'b0);
		rx(8'h11, 1'b1);
		check({7'h0, len_seen}, 8'h01);
		$display("test variable length done");
		// notification answers a request, never a bare pulse end
		tx(0, 4'h0, PIE_PULSE_NOTE);
		busy_seen = 1'b0;
		@(posedge mclk_i);
		#1;
		pulse_done_i = 1'b1;
		@(posedge mclk_i);
		#1;
		pulse_done_i = 1'b0;
		repeat (20) @(posedge mclk_i);
		check({7'h0, busy_seen}, 8'h00);
		for (int s = 0; s < 16; s++) begin
			tx(2, s[3:0], {4'h9, s > 7 ? 4'hf : s[3:0]});
		end
		for (int t = 0; t < 16; t++) begin
			tx(3, t[3:0], {4'hb, t[3:0]});
		end
		for (int c = 0; c < 5; c++) begin
			tx(1, c[3:0], {4'h8, c[3:0]});
		end
		// refused line requests: reserved code, then path present
		for (int r = 0; r < 2; r++) begin
			{drop_seen, busy_seen} = 2'h0;
			@(posedge mclk_i);
			#1;
			line_req_i = 1'b1;
			line_code_i = r == 0 ? 4'h5 : 4'h0;
			path_up_i = r[0];
			repeat (3) @(posedge mclk_i);
			#1;
			line_req_i = 1'b0;
			repeat (20) @(posedge mclk_i);
			#1;
			path_up_i = 1'b0;
			check({6'h0, drop_seen, busy_seen}, 8'h02);
		end
		check({7'h0, frame_err}, 8'h00);
		$display("test outbound elements done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
